/* File: rtl/periph_port_defines.svh */
// Constants for the peripheral master port
`ifndef PERIPH_PORT_DEFINES_SVH
`define PERIPH_PORT_DEFINES_SVH
`define TRANS_IDLE    2'h0
`define TRANS_NONSEQ  2'h2
`define BURST_SINGLE  3'h0
`define SIZE_BYTE     3'h0
`define SIZE_HALF     3'h1
`define SIZE_WORD     3'h2
`define PROT_DATA_BIT 0
`define WORD_STEP     32'h4
`define CNT_ONE       4'h1
`define CNT_TWO       4'h2
`define CNT_ZERO      4'h0
`define PROT_DEFAULT  4'h1
`define RESP_ERROR    1'h1
`define MAX_REGS      4'hF
`endif

/* File: rtl/periph_port_pkg.sv */
// Types for the peripheral master port
package periph_port_pkg;
  typedef enum logic [2:0] {
    OP_BYTE     = 3'h0,
    OP_HALF     = 3'h1,
    OP_WORD     = 3'h2,
    OP_MULTIPLE = 3'h3,
    OP_DOUBLE   = 3'h4
  } op_kind_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b100
  } port_state_e;
endpackage : periph_port_pkg

/* File: rtl/periph_align_check.sv */
// Alignment check and transfer sizing for one request
`timescale 1ns/1ps
`include "periph_port_defines.svh"
module periph_align_check
  import periph_port_pkg::*;
(
  input  wire logic [2:0] op_kind,      // Requested operation
  input  wire logic [1:0] addr_low,     // Low address bits
  input  wire logic       strict_order, // Device or strongly-ordered target
  input  wire logic       exclusive,    // Exclusive access
  output logic            misaligned,   // Alignment fault condition
  output logic      [2:0] width         // Transfer size code
);
  always_comb begin
    unique case (op_kind)
      OP_BYTE: width = `SIZE_BYTE;
      OP_HALF: width = `SIZE_HALF;
      default: width = `SIZE_WORD;
    endcase
    misaligned = 1'b0;
    if (strict_order || exclusive || op_kind == OP_MULTIPLE || op_kind == OP_DOUBLE) begin
      if (width == `SIZE_HALF)
        misaligned = addr_low[0];
      else if (width == `SIZE_WORD)
        misaligned = |addr_low;
    // Normal memory is refused alike: splitting an unaligned access is not built
    end else if (width == `SIZE_HALF) begin
      misaligned = addr_low[0];
    end else if (width == `SIZE_WORD) begin
      misaligned = |addr_low;
    end
  end
endmodule : periph_align_check

/* File: rtl/peripheral_master_port.sv */
// AHB-Lite peripheral master port turning loads and stores into single transfers
`timescale 1ns/1ps
`include "periph_port_defines.svh"
module peripheral_master_port
  import periph_port_pkg::*;
(
  input  wire logic        clk,                    // 40 MHz clock
  input  wire logic        rst_n,                  // Async reset, active low
  input  wire logic        req_valid,              // Load/store request
  output logic             req_ready,              // Request accepted
  input  wire logic  [2:0] req_op,                 // Operation kind
  input  wire logic        req_write,              // Store when high
  input  wire logic [31:0] req_addr,               // Byte address
  input  wire logic  [3:0] req_count,              // Register count for multiple
  input  wire logic        req_strict,             // Device/strongly-ordered target
  input  wire logic        req_exclusive,          // Exclusive access
  input  wire logic  [3:0] req_prot,               // Privilege etc, bit 0 forced
  input  wire logic [31:0] wr_data,                // Store data for current beat
  output logic             wr_data_take,           // Store data consumed this cycle
  output logic             rd_valid,               // Load data beat valid
  output logic      [31:0] rd_data,                // Load data beat
  output logic             op_done,                // Operation finished, pulse
  output logic             op_error,               // Slave error on finish, pulse
  output logic             alignment_fault_exception, // Fault pulse, no transfer
  output logic      [31:0] periph_byte_address,    // HADDR
  output logic       [1:0] periph_transfer_kind,   // HTRANS
  output logic       [2:0] periph_burst_kind,      // HBURST
  output logic       [2:0] periph_transfer_width,  // HSIZE
  output logic       [3:0] periph_protection_bits, // HPROT
  output logic             periph_write,           // HWRITE
  output logic      [31:0] periph_write_data,      // HWDATA
  input  wire logic [31:0] periph_read_data,       // HRDATA
  input  wire logic        periph_ready,           // HREADY
  input  wire logic        periph_resp             // HRESP
);
  port_state_e state_q, state_d;
  logic [31:0] addr_q, addr_d;
  logic  [2:0] width_q, width_d;
  logic  [3:0] left_q, left_d;
  logic        write_q, write_d;
  logic  [3:0] prot_q, prot_d;
  logic        err_q, err_d;
  logic [31:0] wdata_q, wdata_d;
  logic        rd_valid_q, rd_valid_d;
  logic [31:0] rd_data_q, rd_data_d;
  logic        done_q, done_d;
  logic        fault_q, fault_d;
  logic        misaligned;
  logic  [2:0] req_width;
  logic  [3:0] beats;

  periph_align_check u_align (
    .op_kind      (req_op),
    .addr_low     (req_addr[1:0]),
    .strict_order (req_strict),
    .exclusive    (req_exclusive),
    .misaligned   (misaligned),
    .width        (req_width)
  );

  // Beat count: multiple uses its register count (one beat when it is zero), doubleword two words
  function automatic logic [3:0] beat_count(input logic [2:0] op, input logic [3:0] cnt);
    unique case (op)
      OP_MULTIPLE: beat_count = (cnt == 4'h0) ? `CNT_ONE : cnt;
      OP_DOUBLE:   beat_count = `CNT_TWO;
      default:     beat_count = `CNT_ONE;
    endcase
  endfunction : beat_count

  assign beats     = beat_count(req_op, req_count);
  assign req_ready = state_q == ST_IDLE;

  always_comb begin
    state_d    = state_q;
    addr_d     = addr_q;
    width_d    = width_q;
    left_d     = left_q;
    write_d    = write_q;
    prot_d     = prot_q;
    err_d      = err_q;
    wdata_d    = wdata_q;
    rd_valid_d = 1'b0;
    rd_data_d  = rd_data_q;
    done_d     = 1'b0;
    fault_d    = 1'b0;
    wr_data_take = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (req_valid) begin
          if (misaligned) begin
            fault_d = 1'b1;
          end else begin
            addr_d  = req_addr;
            width_d = req_width;
            left_d  = beats;
            write_d = req_write;
            prot_d  = req_prot | `PROT_DEFAULT;
            err_d   = 1'b0;
            state_d = ST_ADDR;
          end
        end
      end
      ST_ADDR: begin
        // Address phase is taken once the previous data phase is ready
        if (periph_ready) begin
          state_d = ST_DATA;
          if (write_q) begin
            wdata_d      = wr_data;
            wr_data_take = 1'b1;
          end
        end
      end
      ST_DATA: begin
        if (periph_ready) begin
          if (periph_resp == `RESP_ERROR)
            err_d = 1'b1;
          if (!write_q) begin
            rd_valid_d = 1'b1;
            rd_data_d  = periph_read_data;
          end
          if (left_q == `CNT_ONE) begin
            done_d  = 1'b1;
            state_d = ST_IDLE;
          end else begin
            left_d  = left_q - `CNT_ONE;
            addr_d  = addr_q + `WORD_STEP;
            state_d = ST_ADDR;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= ST_IDLE;
      addr_q     <= 32'h0;
      width_q    <= `SIZE_WORD;
      left_q     <= 4'h0;
      write_q    <= 1'b0;
      prot_q     <= `PROT_DEFAULT;
      err_q      <= 1'b0;
      wdata_q    <= 32'h0;
      rd_valid_q <= 1'b0;
      rd_data_q  <= 32'h0;
      done_q     <= 1'b0;
      fault_q    <= 1'b0;
    end else begin
      state_q    <= state_d;
      addr_q     <= addr_d;
      width_q    <= width_d;
      left_q     <= left_d;
      write_q    <= write_d;
      prot_q     <= prot_d;
      err_q      <= err_d;
      wdata_q    <= wdata_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q  <= rd_data_d;
      done_q     <= done_d;
      fault_q    <= fault_d;
    end
  end

  // Every transfer is NONSEQ SINGLE; only data accesses leave this port
  assign periph_transfer_kind   = (state_q == ST_ADDR) ? `TRANS_NONSEQ : `TRANS_IDLE;
  assign periph_burst_kind      = `BURST_SINGLE;
  assign periph_byte_address    = addr_q;
  assign periph_transfer_width  = width_q;
  assign periph_protection_bits = prot_q;
  assign periph_write           = write_q;
  assign periph_write_data      = wdata_q;
  assign rd_valid               = rd_valid_q;
  assign rd_data                = rd_data_q;
  assign op_done                = done_q;
  assign op_error               = done_q & err_q;
  assign alignment_fault_exception = fault_q;

  // Natural alignment for the size a request asks for; word-wide kinds need both low bits clear
  function automatic logic size_misaligned(input logic [2:0] op, input logic [1:0] low);
    unique case (op)
      OP_BYTE: size_misaligned = 1'b0;
      OP_HALF: size_misaligned = low[0];
      default: size_misaligned = |low;
    endcase
  endfunction : size_misaligned

  // Checker bookkeeping: address phases issued against the beats promised at acceptance
  logic  [3:0] issued_q, issued_d;
  logic  [3:0] total_q, total_d;

  always_comb begin
    issued_d = issued_q;
    total_d  = total_q;
    if (req_valid && req_ready && !misaligned) begin
      issued_d = `CNT_ZERO;
      total_d  = beats;
    end else if (periph_transfer_kind == `TRANS_NONSEQ && periph_ready) begin
      issued_d = issued_q + `CNT_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      issued_q <= `CNT_ZERO;
      total_q  <= `CNT_ZERO;
    end else begin
      issued_q <= issued_d;
      total_q  <= total_d;
    end
  end

  AST_BURST_SINGLE: assert property (@(posedge clk) disable iff (!rst_n)
    periph_burst_kind == `BURST_SINGLE) else $error("burst not single");
  AST_TRANS_KIND: assert property (@(posedge clk) disable iff (!rst_n)
    periph_transfer_kind == `TRANS_IDLE || periph_transfer_kind == `TRANS_NONSEQ)
    else $error("illegal transfer kind");
  AST_SIZE_MAX: assert property (@(posedge clk) disable iff (!rst_n)
    periph_transfer_kind == `TRANS_NONSEQ |-> periph_transfer_width <= `SIZE_WORD)
    else $error("size too wide");
  AST_PROT_DATA: assert property (@(posedge clk) disable iff (!rst_n)
    periph_transfer_kind == `TRANS_NONSEQ |-> periph_protection_bits[`PROT_DATA_BIT])
    else $error("prot bit 0 low");
  AST_NO_CROSS: assert property (@(posedge clk) disable iff (!rst_n)
    periph_transfer_kind == `TRANS_NONSEQ |->
      !(periph_transfer_width == `SIZE_HALF && periph_byte_address[0]) &&
      !(periph_transfer_width == `SIZE_WORD && |periph_byte_address[1:0]))
    else $error("transfer misaligned or crossing");
  AST_FAULT_NO_XFER: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && req_ready && misaligned |=> alignment_fault_exception && state_q == ST_IDLE)
    else $error("fault did not block transfer");
  AST_STEP_FOUR: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_DATA && periph_ready && left_q != `CNT_ONE |=>
      periph_byte_address == $past(periph_byte_address) + `WORD_STEP)
    else $error("address step not four");
  AST_IDLE_WHEN_FREE: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_IDLE |-> periph_transfer_kind == `TRANS_IDLE)
    else $error("not idle while free");
  AST_SIZE_MATCH: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && req_ready && !misaligned |=> periph_transfer_kind == `TRANS_NONSEQ &&
      periph_transfer_width == $past(req_width)) else $error("size differs from request");
  AST_DEV_ALIGN: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && req_ready && req_strict && size_misaligned(req_op, req_addr[1:0]) |=>
      alignment_fault_exception && periph_transfer_kind == `TRANS_IDLE) else $error("device access not aligned");
  AST_EXCL_ALIGN: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && req_ready && req_exclusive && size_misaligned(req_op, req_addr[1:0]) |=>
      alignment_fault_exception && periph_transfer_kind == `TRANS_IDLE) else $error("exclusive access not aligned");
  AST_WIDE_WORDS: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && req_ready && !size_misaligned(req_op, req_addr[1:0]) && (req_op == OP_MULTIPLE ||
      req_op == OP_DOUBLE) |=> periph_transfer_width == `SIZE_WORD) else $error("wide access not in words");
  AST_BYTE_EXACT: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && req_ready && req_op == OP_BYTE |=> periph_transfer_kind == `TRANS_NONSEQ &&
      periph_byte_address == $past(req_addr) && periph_transfer_width == `SIZE_BYTE)
    else $error("byte access not at its own address");
  AST_HALF_EXACT: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && req_ready && req_op == OP_HALF && !req_addr[0] |=> periph_transfer_kind == `TRANS_NONSEQ &&
      periph_byte_address == $past(req_addr) && periph_transfer_width == `SIZE_HALF)
    else $error("halfword access not at its own address");
  AST_HALF_LOAD_FAULT: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && req_ready && req_strict && !req_write && req_op == OP_HALF && req_addr[0] |=>
      alignment_fault_exception && periph_transfer_kind == `TRANS_IDLE) else $error("odd halfword load not faulted");
  AST_WORD_LOAD_FAULT: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && req_ready && req_strict && !req_write && req_op == OP_WORD && |req_addr[1:0] |=>
      alignment_fault_exception && periph_transfer_kind == `TRANS_IDLE) else $error("unaligned word load not faulted");
  AST_HALF_STORE_FAULT: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid && req_ready && req_strict && req_write && req_op == OP_HALF && req_addr[0] |=>
      alignment_fault_exception && periph_transfer_kind == `TRANS_IDLE) else $error("odd halfword store not faulted");
  AST_BEATS_DONE: assert property (@(posedge clk) disable iff (!rst_n)
    op_done |-> issued_q == total_q)
    else $error("beat count differs at finish");
  AST_BEAT_LIMIT: assert property (@(posedge clk) disable iff (!rst_n)
    periph_transfer_kind == `TRANS_NONSEQ |-> issued_q < total_q)
    else $error("more transfers than beats");
  AST_DATA_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_DATA && !periph_ready |=> $stable(periph_byte_address) && $stable(periph_transfer_width) &&
      $stable(periph_write) && $stable(periph_write_data)) else $error("transfer changed in wait state");
  AST_ONE_TRANSFER: assert property (@(posedge clk) disable iff (!rst_n)
    periph_transfer_kind == `TRANS_NONSEQ && periph_ready |=> periph_transfer_kind == `TRANS_IDLE)
    else $error("back-to-back address phases");
  AST_DONE_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    op_done |-> periph_transfer_kind == `TRANS_IDLE && req_ready)
    else $error("port busy after finish");
endmodule : peripheral_master_port

/* File: test/ahb_slave_model.sv */
// Behavioural AHB-Lite slave that answers the peripheral master port and logs each completed transfer
`timescale 1ns/1ps
module ahb_slave_model (
  input  wire logic        clk,         // Bus clock
  input  wire logic        rst_n,       // Async reset, active low
  input  wire logic [31:0] haddr,       // Address
  input  wire logic  [1:0] htrans,      // Transfer kind
  input  wire logic  [2:0] hsize,       // Transfer width
  input  wire logic        hwrite,      // Write
  input  wire logic [31:0] hwdata,      // Write data
  input  wire logic  [3:0] wait_cycles, // Wait states per data phase
  input  wire logic        fail_resp,   // Answer every data phase with an error
  output logic             hready,      // Ready
  output logic             hresp,       // Response, error while fail_resp
  output logic      [31:0] hrdata       // Read data
);
  logic        active_q;
  logic [31:0] addr_q;
  logic  [2:0] size_q;
  logic        write_q;
  logic  [3:0] cnt_q;
  logic [31:0] tick_q;
  logic [31:0] seen_addr[$];
  logic  [2:0] seen_size[$];
  logic        seen_write[$];
  logic [31:0] seen_wdata[$];
  // Any width and any address is served alike
  assign hready = !active_q || cnt_q == 4'h0;
  // Error is held through the wait states, so it lasts one cycle more than wait_cycles
  assign hresp  = active_q && fail_resp;
  // Outside a completing read the bus churns, so stale data can never pass as an answer
  assign hrdata = (active_q && cnt_q == 4'h0 && !write_q) ? ~addr_q : tick_q;
  // Plain always: the bench empties the logs between scenarios
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= 1'b0;
      cnt_q    <= 4'h0;
      tick_q   <= 32'h1234_5678;
    end else begin
      tick_q <= tick_q + 32'h9E37_79B9;
      if (active_q && cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
      if (hready) begin
        if (active_q) begin
          seen_addr.push_back(addr_q);
          seen_size.push_back(size_q);
          seen_write.push_back(write_q);
          seen_wdata.push_back(hwdata);
        end
        active_q <= htrans == 2'h2;
        addr_q   <= haddr;
        size_q   <= hsize;
        write_q  <= hwrite;
        cnt_q    <= wait_cycles;
      end
    end
  end
endmodule : ahb_slave_model

/* File: test/peripheral_ahb_master_port_tb.sv */
// Self-checking bench for the peripheral master port against a slave model
`timescale 1ns/1ps
`define CHECK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module peripheral_ahb_master_port_tb;
  import periph_port_pkg::*;
  logic clk = 0, rst_n = 0, req_valid = 0, req_write = 0, req_strict = 0, req_exclusive = 0;
  logic [2:0] req_op = 0;
  logic [31:0] req_addr = 0, wr_data = 0, rd_data, haddr, hwdata, hrdata;
  logic [3:0] req_count = 0, req_prot = 4'h2, hprot, slv_wait = 0;
  logic req_ready, take, rd_valid, op_done, op_error, fault, hwrite, hready, hresp;
  logic [1:0] htrans;
  logic [2:0] hburst, hsize;
  logic slv_fail = 0;
  int failures = 0, checked = 0;
  peripheral_master_port DUT (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_write(req_write), .req_addr(req_addr), .req_count(req_count),
    .req_strict(req_strict), .req_exclusive(req_exclusive), .req_prot(req_prot), .wr_data(wr_data),
    .wr_data_take(take), .rd_valid(rd_valid), .rd_data(rd_data), .op_done(op_done), .op_error(op_error),
    .alignment_fault_exception(fault), .periph_byte_address(haddr), .periph_transfer_kind(htrans),
    .periph_burst_kind(hburst), .periph_transfer_width(hsize), .periph_protection_bits(hprot),
    .periph_write(hwrite), .periph_write_data(hwdata), .periph_read_data(hrdata),
    .periph_ready(hready), .periph_resp(hresp));
  ahb_slave_model slv (.clk(clk), .rst_n(rst_n), .haddr(haddr), .htrans(htrans), .hsize(hsize),
    .hwrite(hwrite), .hwdata(hwdata), .wait_cycles(slv_wait), .fail_resp(slv_fail),
    .hready(hready), .hresp(hresp), .hrdata(hrdata));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // Every address phase is checked against the port's fixed limits
  always @(posedge clk) begin
    if (rst_n && take) wr_data <= wr_data + 32'h1;
    if (rst_n && htrans !== 2'h0) begin
      `CHECK(htrans, 2'h2)
      `CHECK(hburst, 3'h0)
      `CHECK(hprot[0], 1'b1)
      `CHECK(hsize <= 3'h2, 1'b1)
      `CHECK(haddr & ((32'h1 << hsize) - 32'h1), 32'h0)
    end
  end
  task automatic run_op(input logic [2:0] op, input logic wr, input logic [31:0] a, input logic [3:0] cnt,
                        input logic excl, input int beats, input logic flt, input logic [2:0] sz);
    int rdn;
    logic got;
    rdn = 0;
    got = 0;
    slv.seen_addr.delete();
    slv.seen_size.delete();
    slv.seen_write.delete();
    slv.seen_wdata.delete();
    @(posedge clk);
    {req_valid, req_op, req_write, req_addr, req_count, req_exclusive} <= {1'b1, op, wr, a, cnt, excl};
    wr_data <= 32'hC0DE_0000;
    @(posedge clk);
    req_valid <= 1'b0;
    for (int n = 0; n < 200; n++) begin
      #1;
      if (rd_valid) begin
        `CHECK(rd_data, ~(a + 32'h4 * rdn))
        rdn++;
      end
      if (fault) got = 1;
      if (op_done) `CHECK(op_error, slv_fail)
      if (n == 0) `CHECK(req_ready, flt)
      if (op_done || got) break;
      @(posedge clk);
    end
    `CHECK(got, flt)
    `CHECK(rdn, wr ? 0 : beats)
    `CHECK(slv.seen_addr.size(), beats)
    for (int k = 0; k < slv.seen_addr.size() && k < beats; k++) begin
      `CHECK(slv.seen_addr[k], a + 32'h4 * k)
      `CHECK(slv.seen_size[k], sz)
      `CHECK(slv.seen_write[k], wr)
      if (wr) `CHECK(slv.seen_wdata[k], 32'hC0DE_0000 + k)
    end
    @(posedge clk);
    #1;
    `CHECK(htrans, 2'h0)
  endtask : run_op
  task automatic test_byte_loads;
    for (int i = 0; i < 4; i++) run_op(3'h0, 1'b0, 32'h4000_0010 + i, 4'h1, 1'b0, 1, 1'b0, 3'h0);
  endtask : test_byte_loads
  task automatic test_half_loads;
    for (int i = 0; i < 4; i++) run_op(3'h1, 1'b0, 32'h4000_0020 + i, 4'h1, 1'b0, i % 2 ? 0 : 1, i % 2, 3'h1);
  endtask : test_half_loads
  task automatic test_word_loads;
    for (int i = 0; i < 4; i++) run_op(3'h2, 1'b0, 32'h4000_0030 + i, 4'h1, 1'b0, i ? 0 : 1, i != 0, 3'h2);
    run_op(3'h2, 1'b0, 32'h4000_0034, 4'h1, 1'b1, 1, 1'b0, 3'h2);
    req_strict <= 1'b0;
    run_op(3'h1, 1'b0, 32'h4000_0037, 4'h1, 1'b1, 0, 1'b1, 3'h1);
    req_strict <= 1'b1;
  endtask : test_word_loads
  task automatic test_stores;
    slv_wait <= 4'h2;
    run_op(3'h1, 1'b1, 32'h4000_0041, 4'h1, 1'b0, 0, 1'b1, 3'h1);
    run_op(3'h0, 1'b1, 32'h4000_0043, 4'h1, 1'b0, 1, 1'b0, 3'h0);
    run_op(3'h4, 1'b1, 32'h4000_0048, 4'h2, 1'b0, 2, 1'b0, 3'h2);
    slv_fail <= 1'b1;
    run_op(3'h4, 1'b1, 32'h4000_0050, 4'h2, 1'b0, 2, 1'b0, 3'h2);
    slv_fail <= 1'b0;
  endtask : test_stores
  task automatic test_multiple;
    slv_wait <= 4'h3;
    run_op(3'h3, 1'b0, 32'h4000_0004, 4'h5, 1'b0, 5, 1'b0, 3'h2);
    slv_wait <= 4'h0;
    run_op(3'h3, 1'b1, 32'h4000_0000, 4'h5, 1'b0, 5, 1'b0, 3'h2);
  endtask : test_multiple
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  initial begin
    req_strict = 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    test_byte_loads();
    test_half_loads();
    test_word_loads();
    test_stores();
    test_multiple();
    final_report();
  end
  // Whole run needs under two hundred cycles; this span leaves a wide margin
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report();
  end
endmodule : peripheral_ahb_master_port_tb
